// File: rtl/ssb_serial_top.sv
// serial status flags, bit rate divisor and character engine behind apb
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "ssb_params.svh"
module ssb_serial_top (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic lp_enter,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    output logic irq
);
    typedef struct packed {
        logic [5:0] mode;
        logic re;
        logic te;
        logic [7:0] divisor;
        logic [7:0] tx_data_reg;
        logic [7:0] rx_data_reg;
        logic tx_empty_flag;
        logic rx_full_flag;
        logic parity_error_flag;
        logic transmit_end_flag;
        logic rx_multiproc_bit;
        logic tx_multiproc_bit;
        logic seen_tx_empty_flag;
        logic seen_rx_full_flag;
        logic seen_per;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic [31:0] prdata;
        ssb_pkg::ssb_tx_state_type tx_state;
        logic [11:0] tx_frame;
        logic [3:0] tx_left;
        logic [3:0] tx_os;
        logic txd;
    } ssb_core_type;

    ssb_core_type st;
    ssb_core_type next_st;
    localparam logic [7:0] stat_init = `SSB_STAT_RESET;
    ssb_link_if link ();

    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic [7:0] stat_byte;
    logic sync_mode;
    logic mp_eff;
    logic bit_tick;
    logic tx_hold;
    logic set_rx;
    logic set_per;
    logic set_transmit_end_flag;
    logic load_tx;
    logic sw_clr_tx_empty_flag;
    logic sw_clr_rx_full_flag;
    logic sw_clr_per;
    logic par_bit;

    function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic mapped(input logic [11:0] addr);
        mapped = hit(addr, `SSB_OFS_MODE) || hit(addr, `SSB_OFS_CTRL) ||
                 hit(addr, `SSB_OFS_DIV) || hit(addr, `SSB_OFS_STAT) ||
                 hit(addr, `SSB_OFS_TXD) || hit(addr, `SSB_OFS_RXD) ||
                 hit(addr, `SSB_OFS_IRQ_ST) || hit(addr, `SSB_OFS_IRQ_MASK);
    endfunction : mapped

    // read data is captured in setup, so every transfer takes exactly one access cycle
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite && mapped(paddr);
    assign rd = access && !pwrite;
    assign pready = access;
    assign pslverr = access && !mapped(paddr);
    assign prdata = st.prdata;
    assign txd = st.txd;
    assign irq = |(st.irq_st & st.irq_mask);

    assign link.divisor = st.divisor; // RULE_13
    assign link.cks = {st.mode[`SSB_MODE_CKS_HI], st.mode[`SSB_MODE_CKS_LO]};
    assign link.rxd = rxd;
    assign link.par_en = st.mode[`SSB_MODE_PAR_EN];
    assign link.odd = st.mode[`SSB_MODE_ODD];
    assign link.mp_en = st.mode[`SSB_MODE_MP_EN] && !sync_mode;
    // reception halts while the parity error is pending
    assign link.rx_en = st.re && !st.parity_error_flag && !sync_mode; // RULE_05

    ssb_rate_gen u_rate (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .link(link.rate)
    );

    ssb_rx_frame u_rx (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .link(link.rx)
    );

    assign sync_mode = st.mode[`SSB_MODE_SYNC];
    assign mp_eff = st.mode[`SSB_MODE_MP_EN] && !sync_mode && st.te; // RULE_12
    assign tx_hold = sync_mode && st.parity_error_flag; // RULE_05
    assign bit_tick = link.os_tick && !tx_hold &&
                      (sync_mode || st.tx_os == `SSB_OS_LAST); // RULE_17

    assign stat_byte = {st.tx_empty_flag, st.rx_full_flag, 2'b00, st.parity_error_flag, st.transmit_end_flag, st.rx_multiproc_bit, st.tx_multiproc_bit};

    assign sw_clr_tx_empty_flag = wr && hit(paddr, `SSB_OFS_STAT) &&
                         !pwdata[`SSB_ST_TX_EMPTY_FLAG] && st.seen_tx_empty_flag;
    assign sw_clr_rx_full_flag = wr && hit(paddr, `SSB_OFS_STAT) &&
                         !pwdata[`SSB_ST_RX_FULL_FLAG] && st.seen_rx_full_flag;
    assign sw_clr_per = wr && hit(paddr, `SSB_OFS_STAT) &&
                        !pwdata[`SSB_ST_PER] && st.seen_per; // RULE_02

    assign set_rx = link.done && st.re && !link.parity_bad;
    assign set_per = link.done && st.re && link.parity_bad; // RULE_01
    assign load_tx = st.te && !st.tx_empty_flag && (st.tx_state == ssb_pkg::SSB_TX_IDLE) && !tx_hold;
    assign set_transmit_end_flag = !st.te ||
                      (st.tx_state == ssb_pkg::SSB_TX_SHIFT && bit_tick &&
                       st.tx_left == 4'h1 && st.tx_empty_flag); // RULE_06
    assign par_bit = st.mode[`SSB_MODE_ODD] ? ~^st.tx_data_reg : ^st.tx_data_reg;

    always_comb begin
        next_st = st;

        if (setup) begin
            unique case (1'b1)
                hit(paddr, `SSB_OFS_MODE): next_st.prdata = {26'h0, st.mode};
                hit(paddr, `SSB_OFS_CTRL): next_st.prdata = {30'h0, st.te, st.re};
                hit(paddr, `SSB_OFS_DIV): next_st.prdata = {24'h0, st.divisor}; // RULE_14
                hit(paddr, `SSB_OFS_STAT): next_st.prdata = {24'h0, stat_byte};
                hit(paddr, `SSB_OFS_TXD): next_st.prdata = {24'h0, st.tx_data_reg};
                hit(paddr, `SSB_OFS_RXD): next_st.prdata = {24'h0, st.rx_data_reg};
                hit(paddr, `SSB_OFS_IRQ_ST): next_st.prdata = {29'h0, st.irq_st};
                hit(paddr, `SSB_OFS_IRQ_MASK): next_st.prdata = {29'h0, st.irq_mask};
                default: next_st.prdata = 32'h0;
            endcase
        end

        // a one seen by a status read arms the later write-zero clear
        if (rd && hit(paddr, `SSB_OFS_STAT)) begin
            next_st.seen_tx_empty_flag = st.seen_tx_empty_flag || st.tx_empty_flag;
            next_st.seen_rx_full_flag = st.seen_rx_full_flag || st.rx_full_flag;
            next_st.seen_per = st.seen_per || st.parity_error_flag; // RULE_02
        end

        if (wr) begin
            unique case (1'b1)
                hit(paddr, `SSB_OFS_MODE): next_st.mode = pwdata[5:0];
                hit(paddr, `SSB_OFS_CTRL): begin
                    next_st.re = pwdata[`SSB_CTRL_RE];
                    next_st.te = pwdata[`SSB_CTRL_TE];
                end
                hit(paddr, `SSB_OFS_DIV): next_st.divisor = pwdata[7:0]; // RULE_14
                hit(paddr, `SSB_OFS_STAT): next_st.tx_multiproc_bit = pwdata[`SSB_ST_TX_MULTIPROC_BIT]; // RULE_11
                hit(paddr, `SSB_OFS_TXD): next_st.tx_data_reg = pwdata[7:0];
                hit(paddr, `SSB_OFS_IRQ_ST): next_st.irq_st = st.irq_st & ~pwdata[2:0];
                hit(paddr, `SSB_OFS_IRQ_MASK): next_st.irq_mask = pwdata[2:0];
                default: next_st.irq_mask = st.irq_mask;
            endcase
        end

        // clears first, hardware sets afterwards so a set in the same cycle wins
        if (sw_clr_tx_empty_flag || (wr && hit(paddr, `SSB_OFS_TXD))) begin
            next_st.tx_empty_flag = 1'b0;
            next_st.transmit_end_flag = 1'b0; // RULE_07
        end
        if (sw_clr_rx_full_flag || (rd && hit(paddr, `SSB_OFS_RXD))) begin
            next_st.rx_full_flag = 1'b0;
        end
        if (sw_clr_per) begin
            next_st.parity_error_flag = 1'b0; // RULE_02
        end
        if (!next_st.tx_empty_flag) begin
            next_st.seen_tx_empty_flag = 1'b0;
        end
        if (!next_st.rx_full_flag) begin
            next_st.seen_rx_full_flag = 1'b0;
        end
        if (!next_st.parity_error_flag) begin
            next_st.seen_per = 1'b0;
        end

        // receive side; with re low nothing is touched so flags hold
        if (set_rx) begin
            next_st.rx_data_reg = link.data;
            next_st.rx_full_flag = 1'b1;
            next_st.irq_st[`SSB_IRQ_RX] = 1'b1;
        end
        if (set_per) begin // RULE_03
            next_st.rx_data_reg = link.data; // RULE_04
            next_st.parity_error_flag = 1'b1; // RULE_18
            next_st.irq_st[`SSB_IRQ_PER] = 1'b1;
        end
        if (link.done && st.re && link.mp_en) begin // RULE_10
            next_st.rx_multiproc_bit = link.mpb; // RULE_09
        end

        // transmit engine
        if (st.tx_state == ssb_pkg::SSB_TX_SHIFT && link.os_tick && !tx_hold) begin
            next_st.tx_os = st.tx_os + 4'h1;
        end
        if (st.tx_state == ssb_pkg::SSB_TX_SHIFT && bit_tick) begin
            if (st.tx_left == 4'h1) begin
                next_st.tx_state = ssb_pkg::SSB_TX_IDLE;
                next_st.txd = 1'b1;
            end else begin
                next_st.tx_frame = {1'b1, st.tx_frame[11:1]};
                next_st.txd = st.tx_frame[1];
                next_st.tx_left = st.tx_left - 4'h1;
            end
        end
        if (load_tx) begin
            next_st.tx_state = ssb_pkg::SSB_TX_SHIFT;
            next_st.tx_os = 4'h0;
            next_st.tx_empty_flag = 1'b1;
            if (sync_mode) begin
                next_st.tx_frame = {4'hf, st.tx_data_reg};
                next_st.tx_left = `SSB_SYNC_BITS;
                next_st.txd = st.tx_data_reg[0];
            end else begin
                next_st.tx_frame = {3'b111, st.tx_data_reg, 1'b0};
                next_st.tx_left = `SSB_ASYNC_BITS + {3'b000, st.mode[`SSB_MODE_PAR_EN]} +
                                  {3'b000, mp_eff};
                next_st.txd = 1'b0;
                if (st.mode[`SSB_MODE_PAR_EN]) begin
                    next_st.tx_frame[9] = par_bit;
                end
                if (mp_eff) begin // RULE_11
                    next_st.tx_frame[st.mode[`SSB_MODE_PAR_EN] ? 10 : 9] = st.tx_multiproc_bit;
                end
            end
        end
        if (!st.te) begin
            next_st.tx_empty_flag = 1'b1;
            next_st.tx_state = ssb_pkg::SSB_TX_IDLE;
            next_st.txd = 1'b1;
        end
        if (set_transmit_end_flag) begin
            next_st.transmit_end_flag = 1'b1; // RULE_06
            if (!st.transmit_end_flag) begin
                next_st.irq_st[`SSB_IRQ_TRANSMIT_END_FLAG] = 1'b1;
            end
        end
    end

    // low power entry reinitialises like reset
    always_ff @(posedge core_clk) begin
        if (sys_rst || lp_enter) begin
            st <= '0;
            st.divisor <= `SSB_DIV_RESET; // RULE_15
            st.tx_empty_flag <= stat_init[`SSB_ST_TX_EMPTY_FLAG]; // RULE_16
            st.transmit_end_flag <= stat_init[`SSB_ST_TRANSMIT_END_FLAG]; // RULE_08
            st.txd <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
endmodule : ssb_serial_top

// File: rtl/ssb_params.svh
// constants of the serial status and bit rate block
// Operation
// RULE_01: set parity error when ones of data plus parity disagree with odd/even select
// RULE_02: parity error clears only by writing 0 after reading 1; writing 1 ignored
// RULE_03: clearing receive enable leaves parity error flag as it was
// RULE_04: on parity error data still goes to rx data, rx full stays clear
// RULE_05: while parity error set, no reception; synchronous mode also halts transmission
// RULE_06: transmit end sets when transmit disabled, or tx empty at last bit out
// RULE_07: transmit end clears on software tx empty clear or tx data write
// RULE_08: transmit end is read only and initialises to 1
// RULE_09: async multiprocessor format captures received multiprocessor bit, read only, init 0
// RULE_10: receive enable cleared keeps captured multiprocessor bit unchanged
// RULE_11: async multiprocessor format appends writable tx multiprocessor bit, reset 0
// RULE_12: tx multiprocessor bit ignored in sync mode, format off, or transmit disabled
// RULE_13: bit rate from 8-bit divisor and prescaled clock chosen by two select bits
// RULE_14: divisor readable and writable at any time, no lockout
// RULE_15: divisor loads all ones on reset and low power entry
// RULE_16: status register initialises with only tx empty and transmit end set
// RULE_17: one rate tick per divisor plus one prescaled ticks, 16x oversampled async
// RULE_18: writes act on the next edge; hardware set beats a clearing write
`ifndef SSB_PARAMS_SVH
`define SSB_PARAMS_SVH
`define SSB_OFS_MODE 12'h000
`define SSB_OFS_CTRL 12'h004
`define SSB_OFS_DIV 12'h008
`define SSB_OFS_STAT 12'h00c
`define SSB_OFS_TXD 12'h010
`define SSB_OFS_RXD 12'h014
`define SSB_OFS_IRQ_ST 12'h018
`define SSB_OFS_IRQ_MASK 12'h01c
`define SSB_MODE_PAR_EN 0
`define SSB_MODE_ODD 1
`define SSB_MODE_MP_EN 2
`define SSB_MODE_SYNC 3
`define SSB_MODE_CKS_LO 4
`define SSB_MODE_CKS_HI 5
`define SSB_CTRL_RE 0
`define SSB_CTRL_TE 1
`define SSB_ST_TX_EMPTY_FLAG 7
`define SSB_ST_RX_FULL_FLAG 6
`define SSB_ST_PER 3
`define SSB_ST_TRANSMIT_END_FLAG 2
`define SSB_ST_RX_MULTIPROC_BIT 1
`define SSB_ST_TX_MULTIPROC_BIT 0
`define SSB_IRQ_RX 0
`define SSB_IRQ_PER 1
`define SSB_IRQ_TRANSMIT_END_FLAG 2
`define SSB_STAT_RESET 8'h84
`define SSB_DIV_RESET 8'hff
`define SSB_PRE_LIM0 6'h00
`define SSB_PRE_LIM1 6'h03
`define SSB_PRE_LIM2 6'h0f
`define SSB_PRE_LIM3 6'h3f
`define SSB_OS_MID 4'h7
`define SSB_OS_LAST 4'hf
`define SSB_SYNC_BITS 4'h8
`define SSB_ASYNC_BITS 4'ha
`endif

// File: rtl/ssb_pkg.sv
// types of the serial status and bit rate block
package ssb_pkg;
    typedef enum logic [1:0] {
        SSB_RX_IDLE = 2'b00,
        SSB_RX_START = 2'b01,
        SSB_RX_BITS = 2'b10
    } ssb_rx_state_type;
    typedef enum logic {
        SSB_TX_IDLE = 1'b0,
        SSB_TX_SHIFT = 1'b1
    } ssb_tx_state_type;
    typedef struct packed {
        logic [5:0] pre_cnt;
        logic [7:0] div_cnt;
        logic os_tick;
    } ssb_rate_state_type;
    typedef struct packed {
        ssb_rx_state_type state;
        logic [3:0] os_cnt;
        logic [3:0] bit_cnt;
        logic [9:0] shift;
        logic [7:0] data;
        logic parity_bad;
        logic mpb;
        logic done;
    } ssb_rx_frame_type;
endpackage : ssb_pkg

// File: rtl/ssb_link_if.sv
// carrier between core, rate generator and receiver
`timescale 1ns/1ps
interface ssb_link_if;
    logic [7:0] divisor;
    logic [1:0] cks;
    logic os_tick;
    logic rx_en;
    logic rxd;
    logic par_en;
    logic odd;
    logic mp_en;
    logic [7:0] data;
    logic parity_bad;
    logic mpb;
    logic done;
    modport rate (input divisor, input cks, output os_tick);
    modport rx (input os_tick, input rx_en, input rxd, input par_en, input odd, input mp_en,
                output data, output parity_bad, output mpb, output done);
    modport core (input os_tick, input data, input parity_bad, input mpb, input done,
                  output divisor, output cks, output rx_en, output rxd, output par_en,
                  output odd, output mp_en);
endinterface : ssb_link_if

// File: rtl/ssb_rate_gen.sv
// prescaler and divisor counter producing the oversample tick
`timescale 1ns/1ps
`include "ssb_params.svh"
module ssb_rate_gen (
    input wire logic core_clk,
    input wire logic sys_rst,
    ssb_link_if.rate link
);
    ssb_pkg::ssb_rate_state_type st;
    ssb_pkg::ssb_rate_state_type next_st;
    logic [5:0] pre_lim;

    always_comb begin
        unique case (link.cks)
            2'b00: pre_lim = `SSB_PRE_LIM0;
            2'b01: pre_lim = `SSB_PRE_LIM1;
            2'b10: pre_lim = `SSB_PRE_LIM2;
            2'b11: pre_lim = `SSB_PRE_LIM3;
        endcase
        next_st = st;
        next_st.os_tick = 1'b0;
        if (st.pre_cnt >= pre_lim) begin // RULE_13
            next_st.pre_cnt = 6'h00;
            // divisor may shrink mid count, so compare with >= to avoid a 256 wrap
            if (st.div_cnt >= link.divisor) begin // RULE_17
                next_st.div_cnt = 8'h00;
                next_st.os_tick = 1'b1;
            end else begin
                next_st.div_cnt = st.div_cnt + 8'h01;
            end
        end else begin
            next_st.pre_cnt = st.pre_cnt + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.os_tick = st.os_tick;
endmodule : ssb_rate_gen

// File: rtl/ssb_rx_frame.sv
// asynchronous character receiver, 16x oversampled
`timescale 1ns/1ps
`include "ssb_params.svh"
module ssb_rx_frame (
    input wire logic core_clk,
    input wire logic sys_rst,
    ssb_link_if.rx link
);
    ssb_pkg::ssb_rx_frame_type st;
    ssb_pkg::ssb_rx_frame_type next_st;
    logic [3:0] nbits;

    always_comb begin
        nbits = 4'h8 + {3'b000, link.par_en} + {3'b000, link.mp_en};
        next_st = st;
        next_st.done = 1'b0;
        unique case (st.state)
            ssb_pkg::SSB_RX_IDLE: begin
                if (link.os_tick && !link.rxd) begin
                    next_st.state = ssb_pkg::SSB_RX_START;
                    next_st.os_cnt = 4'h0;
                end
            end
            ssb_pkg::SSB_RX_START: begin
                if (link.os_tick) begin
                    next_st.os_cnt = st.os_cnt + 4'h1;
                    if (st.os_cnt == `SSB_OS_MID) begin
                        next_st.os_cnt = 4'h0;
                        next_st.bit_cnt = 4'h0;
                        next_st.state = link.rxd ? ssb_pkg::SSB_RX_IDLE : ssb_pkg::SSB_RX_BITS;
                    end
                end
            end
            ssb_pkg::SSB_RX_BITS: begin
                if (link.os_tick) begin
                    next_st.os_cnt = st.os_cnt + 4'h1;
                    if (st.os_cnt == `SSB_OS_LAST) begin
                        if (st.bit_cnt == nbits) begin
                            next_st.state = ssb_pkg::SSB_RX_IDLE;
                            next_st.done = 1'b1;
                            next_st.data = st.shift[7:0];
                            next_st.parity_bad = link.par_en &&
                                ((^st.shift[7:0] ^ st.shift[8]) != link.odd); // RULE_01
                            next_st.mpb = link.par_en ? st.shift[9] : st.shift[8]; // RULE_09
                        end else begin
                            next_st.shift[st.bit_cnt] = link.rxd;
                            next_st.bit_cnt = st.bit_cnt + 4'h1;
                        end
                    end
                end
            end
            default: next_st.state = ssb_pkg::SSB_RX_IDLE;
        endcase
        if (!link.rx_en) begin
            next_st.state = ssb_pkg::SSB_RX_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign link.data = st.data;
    assign link.parity_bad = st.parity_bad;
    assign link.mpb = st.mpb;
    assign link.done = st.done;
endmodule : ssb_rx_frame

// File: dv/ssb_serial_properties.sv
// concurrent checks on the serial block ports
`timescale 1ns/1ps
`include "ssb_params.svh"
module ssb_serial_props (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic lp_enter,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd,
    input wire logic irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence rd_setup(logic [11:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence wr_acc(logic [11:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence
    a_ready_access: assert property (psel && penable |-> pready) else $error("pready low in access");
    a_ready_idle: assert property (!(psel && penable) |-> !pready) else $error("pready outside access");
    a_err_unmapped: assert property (psel && penable && paddr > `SSB_OFS_IRQ_MASK |-> pslverr)
        else $error("unmapped access without error");
    a_rd_unmapped: assert property (psel && !penable && !pwrite && paddr > `SSB_OFS_IRQ_MASK |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    // read data stays put in the cycle after each access
    a_prdata_hold: assert property (psel && penable |=> $stable(prdata)) else $error("prdata moved after access");
    a_stat_rst: assert property (disable iff (1'b0) sys_rst ##2 rd_setup(`SSB_OFS_STAT) |=> prdata == 32'h84)
        else $error("status wrong after reset");
    a_lp_div: assert property (lp_enter ##2 rd_setup(`SSB_OFS_DIV) |=> prdata == 32'hff)
        else $error("divisor not reloaded on low power entry");
    a_div_write: assert property (wr_acc(`SSB_OFS_DIV) ##2 rd_setup(`SSB_OFS_DIV) |=>
        prdata == ($past(pwdata, 3) & 32'h000000ff)) else $error("divisor readback wrong");
    a_txd_rst: assert property (disable iff (1'b0) sys_rst |=> txd) else $error("txd not idle after reset");
    a_irq_rst: assert property (disable iff (1'b0) sys_rst || lp_enter |=> !irq) else $error("irq after reset");
    a_mask_off: assert property (wr_acc(`SSB_OFS_IRQ_MASK) ##0 (pwdata[2:0] == 3'h0) |=> !irq)
        else $error("irq with mask cleared");
endmodule : ssb_serial_props
bind ssb_serial_top ssb_serial_props chk (.core_clk(core_clk), .sys_rst(sys_rst), .lp_enter(lp_enter), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));

// File: dv/ssb_remote_station.sv
// remote serial station: sends frames on rxd, captures frames from txd
`timescale 1ns/1ps
module ssb_remote_station #(parameter int BIT_CLKS = 16) (
    input wire logic core_clk,
    output logic rxd,
    input wire logic txd
);
    logic [9:0] cap;
    int frames;
    initial begin
        rxd = 1'b1;
        frames = 0;
        cap = 10'h000;
    end
    // start, nine payload bits lsb first, stop; line idles high after
    task automatic send(input logic [8:0] w);
        logic [10:0] f;
        f = {1'b1, w, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge core_clk);
            rxd <= f[i];
            repeat (BIT_CLKS - 1) @(posedge core_clk);
        end
    endtask : send
    // mid-bit sampling keeps clear of the registered edge of txd
    always begin
        @(negedge txd);
        repeat (BIT_CLKS / 2) @(posedge core_clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CLKS) @(posedge core_clk);
            cap[i] = txd;
        end
        frames++;
    end
endmodule : ssb_remote_station

// File: dv/testbench.sv
// register level tests of the serial status and bit rate block
`timescale 1ns/1ps
`include "ssb_params.svh"
module testbench;
    logic core_clk, sys_rst, lp_enter, psel, penable, pwrite, pready, pslverr, rxd, txd, irq, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int err_total, checks, cyc;
    ssb_serial_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .lp_enter(lp_enter), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
    // divisor 0 and prescale 0 give 16 clocks a bit
    ssb_remote_station #(.BIT_CLKS(16)) peer (.core_clk(core_clk), .rxd(rxd), .txd(txd));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd
    task automatic lp;
        @(posedge core_clk);
        lp_enter <= 1'b1;
        @(posedge core_clk);
        lp_enter <= 1'b0;
    endtask : lp
    task automatic send_wait(input logic [8:0] w);
        peer.send(w);
        repeat (24) @(posedge core_clk);
    endtask : send_wait
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        int f;
        sys_rst = 1'b1;
        lp_enter = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(`SSB_OFS_STAT, 32'h84);
        rd(`SSB_OFS_DIV, 32'hff);
        apb(1'b1, `SSB_OFS_DIV, 32'h5a);
        rd(`SSB_OFS_DIV, 32'h5a);
        lp();
        rd(`SSB_OFS_DIV, 32'hff);
        lp();
        rd(`SSB_OFS_STAT, 32'h84);
        rd(12'h020, 32'h0);
        check({31'h0, last_err}, 32'h1);
        apb(1'b1, `SSB_OFS_STAT, 32'hff);
        rd(`SSB_OFS_STAT, 32'h85);
        apb(1'b1, `SSB_OFS_STAT, 32'h80);
        rd(`SSB_OFS_STAT, 32'h84);
        apb(1'b1, `SSB_OFS_DIV, 32'h0);
        apb(1'b1, `SSB_OFS_MODE, 32'h3);
        apb(1'b1, `SSB_OFS_CTRL, 32'h1);
        apb(1'b1, `SSB_OFS_IRQ_MASK, 32'h2);
        send_wait(9'h10f);
        rd(`SSB_OFS_STAT, 32'hc4);
        rd(`SSB_OFS_RXD, 32'h0f);
        rd(`SSB_OFS_STAT, 32'h84);
        apb(1'b1, `SSB_OFS_MODE, 32'h1);
        send_wait(9'h001);
        // zero written without a prior read of one must not clear
        apb(1'b1, `SSB_OFS_STAT, 32'h84);
        rd(`SSB_OFS_STAT, 32'h8c);
        check({31'h0, irq}, 32'h1);
        rd(`SSB_OFS_RXD, 32'h01);
        send_wait(9'h055);
        rd(`SSB_OFS_RXD, 32'h01);
        apb(1'b1, `SSB_OFS_IRQ_MASK, 32'h0);
        @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, `SSB_OFS_IRQ_MASK, 32'h2);
        apb(1'b1, `SSB_OFS_CTRL, 32'h0);
        rd(`SSB_OFS_STAT, 32'h8c);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, `SSB_OFS_STAT, 32'h8c);
        rd(`SSB_OFS_STAT, 32'h8c);
        apb(1'b1, `SSB_OFS_STAT, 32'h84);
        rd(`SSB_OFS_STAT, 32'h84);
        apb(1'b1, `SSB_OFS_IRQ_ST, 32'h2);
        @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, `SSB_OFS_MODE, 32'h4);
        apb(1'b1, `SSB_OFS_CTRL, 32'h1);
        send_wait(9'h133);
        rd(`SSB_OFS_STAT, 32'hc6);
        apb(1'b1, `SSB_OFS_CTRL, 32'h0);
        send_wait(9'h022);
        rd(`SSB_OFS_STAT, 32'hc6);
        rd(`SSB_OFS_RXD, 32'h33);
        apb(1'b1, `SSB_OFS_STAT, 32'h85);
        apb(1'b1, `SSB_OFS_CTRL, 32'h2);
        f = peer.frames;
        apb(1'b1, `SSB_OFS_TXD, 32'ha5);
        rd(`SSB_OFS_STAT, 32'h83);
        while (peer.frames == f) @(posedge core_clk);
        check({22'h0, peer.cap}, 32'h3a5);
        repeat (24) @(posedge core_clk);
        rd(`SSB_OFS_STAT, 32'h87);
        apb(1'b1, `SSB_OFS_STAT, 32'h84);
        apb(1'b1, `SSB_OFS_MODE, 32'h0);
        f = peer.frames;
        apb(1'b1, `SSB_OFS_TXD, 32'h5a);
        while (peer.frames == f) @(posedge core_clk);
        check({22'h0, peer.cap}, 32'h35a);
        // prescale 4 and divisor 1 stretch a frame to about 1280 clocks
        repeat (24) @(posedge core_clk);
        apb(1'b1, `SSB_OFS_DIV, 32'h1);
        apb(1'b1, `SSB_OFS_MODE, 32'h10);
        apb(1'b1, `SSB_OFS_TXD, 32'h0f);
        repeat (1000) @(posedge core_clk);
        rd(`SSB_OFS_STAT, 32'h82);
        repeat (400) @(posedge core_clk);
        rd(`SSB_OFS_STAT, 32'h86);
        repeat (24) @(posedge core_clk);
        apb(1'b1, `SSB_OFS_TXD, 32'h3c);
        apb(1'b1, `SSB_OFS_CTRL, 32'h0);
        rd(`SSB_OFS_STAT, 32'h86);
        conclude();
    end
endmodule : testbench
